// *** sim/core_model.sv ***
// behavioural processor core driving the interrupt entry handshake
module core_model
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             eiCmd,
  input  wire logic             retiCmd,
  input  wire logic             haltCmd,
  input  wire logic             irqAccept,
  input  wire logic             pushStatusWord,
  input  wire irq_pkg::status_s statusOut,
  output      logic             instrDone,
  output      logic             haltActive,
  output      logic             eiExec,
  output      logic             retiDone,
  output      irq_pkg::status_s poppedStatus
);
  timeunit 1ns;
  timeprecision 1ns;
  import irq_pkg::*;
  logic [1:0] lag;
  status_s    stack [$];
  // the running instruction takes a few cycles, so entry must wait for it
  always @(posedge clk)
  begin
    eiExec <= eiCmd & !rst;
    retiDone <= retiCmd & !rst;
    instrDone <= 1'b0;
    if (rst)
    begin
      lag <= 2'h0;
      haltActive <= 1'b0;
      poppedStatus <= 4'h0;
      stack.delete();
    end
    else
    begin
      if (haltCmd)
        haltActive <= 1'b1;
      if (lag != 2'h0)
        lag <= lag - 2'h1;
      if (irqAccept)
      begin
        haltActive <= 1'b0;
        lag <= 2'h3;
      end
      if (lag == 2'h1)
        instrDone <= 1'b1;
      if (pushStatusWord)
        stack.push_back(statusOut);
      if (retiCmd)
        poppedStatus <= stack.pop_back();
    end
  end
endmodule : core_model

// *** sim/vectored_irq_level_control_tb_top.sv ***
// self-checking bench for the interrupt level controller
`include "irq_params.svh"
module vectored_irq_level_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import irq_pkg::*;
  logic        clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, irq, nmiReq, instrDone;
  logic        haltActive, eiExec, diExec, retiDone, wakeUp, irqAccept;
  logic        pushStatusWord, pushPc, loadPc, eiCmd, retiCmd, haltCmd;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [23:0] srcReq, vectorAddr;
  logic [15:0] base;
  status_s     poppedStatus, statusOut;
  int          n_mismatch, samples_checked, cyc;

  vectored_irq_level_control dut_u
  (
    .clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .irq, .srcReq, .nmiReq, .instrDone,
    .haltActive, .eiExec, .diExec, .retiDone, .poppedStatus,
    .wakeUp, .irqAccept, .pushStatusWord, .pushPc, .loadPc, .vectorAddr,
    .statusOut
  );
  core_model core_u
  (
    .clk, .rst, .eiCmd, .retiCmd, .haltCmd, .irqAccept, .pushStatusWord,
    .statusOut, .instrDone, .haltActive, .eiExec, .retiDone, .poppedStatus
  );

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // both channels offered at once, each released on its own handshake
  task automatic axi_wr(input logic [7:0] a, input logic [15:0] d,
                        input logic [1:0] er);
    logic aw, w, b;
    b = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b)
    begin
      @(negedge clk);
      aw = awvalid & awready;
      w = wvalid & wready;
      b = bvalid & bready;
      if (b)
        chk(bresp, er);
      @(posedge clk);
      if (aw)
        awvalid <= 1'b0;
      if (w)
        wvalid <= 1'b0;
      if (b)
        bready <= 1'b0;
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e);
    logic ar, r;
    r = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r)
    begin
      @(negedge clk);
      ar = arvalid & arready;
      r = rvalid & rready;
      if (r)
      begin
        chk(rdata, e);
        chk(rresp, `RESP_OKAY);
      end
      @(posedge clk);
      if (ar)
        arvalid <= 1'b0;
      if (r)
        rready <= 1'b0;
    end
  endtask : axi_rd

  task automatic quiet(input int n);
    repeat (n)
    begin
      @(negedge clk);
      chk(irqAccept, 1'b0);
    end
  endtask : quiet

  task automatic pulse_ei();
    @(posedge clk);
    eiCmd <= 1'b1;
    @(posedge clk);
    eiCmd <= 1'b0;
  endtask : pulse_ei

  task automatic reti(input status_s e);
    @(posedge clk);
    retiCmd <= 1'b1;
    @(posedge clk);
    retiCmd <= 1'b0;
    repeat (2) @(negedge clk);
    chk(statusOut, e);
  endtask : reti

  // step spacing is measured from the end of the running instruction
  task automatic entry(input vector_t v, input status_s st, input logic w);
    int c, cd, cp, cq, cl;
    cd = 0;
    cp = 0;
    cq = 0;
    cl = -1;
    do @(negedge clk); while (irqAccept !== 1'b1);
    chk(wakeUp, w);
    @(posedge clk);
    nmiReq <= 1'b0;
    for (c = 0; c < 30 && cl < 0; c++)
    begin
      @(negedge clk);
      if (instrDone)
        cd = c;
      if (pushStatusWord)
        cp = c;
      if (pushPc)
        cq = c;
      if (loadPc)
        cl = c;
    end
    chk(cp - cd, 1);
    chk(cq - cd, 2);
    chk(cl - cd, 4);
    chk(vectorAddr, {base, 1'b0, v, 2'b00});
    @(negedge clk);
    chk(statusOut, st);
  endtask : entry

  task automatic t_reset();
    axi_rd(`OFF_VBL, 32'h0000_8000);
    axi_rd(`OFF_VBH, 32'h0000_0000);
    for (int x = 0; x < 12; x++)
      axi_rd(8'(`OFF_LVL0 + 4 * x), 32'h0000_0000);
    @(negedge clk);
    chk(irq, 1'b0);
  endtask : t_reset

  task automatic t_regs();
    for (int x = 0; x < 12; x++)
    begin
      axi_wr(8'(`OFF_LVL0 + 4 * x), 16'hFFFF, `RESP_OKAY);
      axi_rd(8'(`OFF_LVL0 + 4 * x), 32'h0000_0707);
    end
    axi_wr(`OFF_VBH, 16'hFFFF, `RESP_OKAY);
    axi_rd(`OFF_VBH, 32'h0000_0000);
    axi_wr(`OFF_MASK, 16'h0002, `RESP_OKAY);
    @(negedge clk);
    chk(irq, 1'b1);
    axi_wr(`OFF_STAT, 16'h0002, `RESP_OKAY);
    @(negedge clk);
    chk(irq, 1'b0);
    axi_wr(`OFF_PROTECT_KEY, `PROTECT_KEY_KEY, `RESP_OKAY);
    axi_rd(`OFF_PROTECT_KEY, 32'h0000_0001);
    axi_wr(`OFF_VBL, 16'h12FF, `RESP_OKAY);
    axi_wr(`OFF_VBH, 16'hAB34, `RESP_OKAY);
    axi_rd(`OFF_VBL, 32'h0000_1200);
    axi_rd(`OFF_VBH, 32'h0000_0034);
    axi_wr(`OFF_PROTECT_KEY, 16'h0000, `RESP_OKAY);
    axi_rd(`OFF_PROTECT_KEY, 32'h0000_0000);
    axi_wr(`OFF_VBL, 16'h5500, `RESP_OKAY);
    axi_rd(`OFF_VBL, 32'h0000_1200);
    axi_wr(8'hF0, 16'h1234, `RESP_SLVERR);
    axi_wr(`OFF_MASK, 16'h0001, `RESP_OKAY);
    axi_rd(`OFF_MASK, 32'h0000_0001);
    axi_rd(`OFF_STAT, 32'h0000_0002);
  endtask : t_regs

  // sources 3 and 5 tie at level 5, 7 sits lower, 23 is set back to level 0
  task automatic t_entry();
    axi_wr(8'h14, 16'h0500, `RESP_OKAY);
    axi_wr(8'h18, 16'h0500, `RESP_OKAY);
    axi_wr(8'h1C, 16'h0200, `RESP_OKAY);
    axi_wr(8'h20, 16'h0600, `RESP_OKAY);
    axi_wr(`OFF_LVL_LAST, 16'h0000, `RESP_OKAY);
    @(posedge clk);
    srcReq <= 24'h80_00A8;
    quiet(8);
    pulse_ei();
    entry(5'h03, 4'hA, 1'b0);
    chk(irq, 1'b1);
    axi_rd(`OFF_CORE, 32'h0000_000A);
  endtask : t_entry

  task automatic t_nest();
    pulse_ei();
    quiet(6);
    @(posedge clk);
    srcReq <= 24'h80_02A8;
    entry(5'h09, 4'hC, 1'b0);
    @(posedge clk);
    srcReq <= 24'h80_00A8;
    reti(4'hB);
    quiet(4);
  endtask : t_nest

  // a non-maskable wake keeps the level field as it was
  task automatic t_halt();
    @(posedge clk);
    haltCmd <= 1'b1;
    @(posedge clk);
    haltCmd <= 1'b0;
    nmiReq <= 1'b1;
    entry(5'h00, 4'hA, 1'b1);
    reti(4'hB);
    @(posedge clk);
    srcReq <= 24'h80_0000;
    reti(4'h1);
    quiet(6);
    @(posedge clk);
    diExec <= 1'b1;
    @(posedge clk);
    diExec <= 1'b0;
    srcReq <= 24'h80_00A8;
    quiet(4);
    chk(statusOut, 4'h0);
  endtask : t_halt

  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {nmiReq, eiCmd, retiCmd, haltCmd, diExec} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    srcReq = 24'h00_0000;
    base = 16'h3412;
    rst = 1'b1;
    n_mismatch = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_entry();
    t_nest();
    t_halt();
    complete_run();
  end
endmodule : vectored_irq_level_control_tb_top

// *** src/arb_if.sv ***
// request/level bundle between register file and level arbiter
`include "irq_params.svh"
interface arb_if;
  import irq_pkg::*;
  logic [`IRQ_SOURCES-1:0] req;
  level_t                  level [`IRQ_SOURCES];
  logic                    valid;
  vector_t                 vec;
  level_t                  lvl;
  modport src (output req, output level, input valid, input vec, input lvl);
  modport arb (input req, input level, output valid, output vec, output lvl);
endinterface : arb_if

// *** src/irq_params.svh ***
// constants of the vectored interrupt level controller
`ifndef IRQ_PARAMS_SVH
`define IRQ_PARAMS_SVH
`define IRQ_SOURCES   24
`define LVL_W         3
`define VEC_W         5
`define ADDR_W        8
`define OFF_VBL       8'h00
`define OFF_VBH       8'h04
`define OFF_LVL0      8'h10
`define OFF_LVL_LAST  8'h3C
`define OFF_PROTECT_KEY      8'h40
`define OFF_STAT      8'h44
`define OFF_MASK      8'h48
`define OFF_CORE      8'h4C
`define LVL_BASE_IDX  4'h4
`define VBL_RST       8'h80
`define VBH_RST       8'h00
`define PROTECT_KEY_RST      16'h0000
`define PROTECT_KEY_KEY      16'h0096
`define LVL_RST       3'h0
`define LVL_LO_LSB    0
`define LVL_HI_LSB    8
`define EV_W          2
`define EV_ACCEPT     0
`define EV_PROTVIOL   1
`define RESP_OKAY     2'b00
`define RESP_SLVERR   2'b10
`endif

// *** src/irq_pkg.sv ***
// types shared by the interrupt controller modules
`include "irq_params.svh"
package irq_pkg;
  typedef logic [`LVL_W-1:0] level_t;
  typedef logic [`VEC_W-1:0] vector_t;
  typedef struct packed
  {
    level_t il;
    logic   ie;
  } status_s;
  typedef enum logic [2:0]
  {
    S_IDLE    = 3'b000,
    S_WAIT    = 3'b001,
    S_PUSH_SR = 3'b010,
    S_PUSH_PC = 3'b011,
    S_MASK    = 3'b100,
    S_VECTOR  = 3'b101
  } entry_state_e;
endpackage : irq_pkg

// *** src/level_arbiter.sv ***
// picks the highest-level pending source, lowest vector on a tie
`include "irq_params.svh"
module level_arbiter
  import irq_pkg::*;
(
  arb_if.arb bus
);
  always_comb
  begin
    bus.valid = 1'b0;
    bus.vec   = '0;
    bus.lvl   = '0;
    // scan downward with >= so an equal level at a lower vector wins
    for (int i = `IRQ_SOURCES - 1; i >= 0; i--)
    begin
      if (bus.req[i] && bus.level[i] != `LVL_RST       // see R14
          && bus.level[i] >= bus.lvl)                   // see R15
      begin
        bus.valid = 1'b1;
        bus.vec   = vector_t'(i);
        bus.lvl   = bus.level[i];
      end
    end
  end
endmodule : level_arbiter

// *** src/vectored_irq_level_control.sv ***
// interrupt level registers, arbitration and core interrupt entry
// Functional notes
// R1: core samples requests each cycle, enters after instruction
// R2: entry first pushes status word and counter
// R3: entry clears global enable flag to zero
// R4: entry loads accepted level; non-maskable keeps level
// R5: last step loads vector into program counter
// R6: nested request needs level above serviced level
// R7: return restores status word and resumes after
// R8: wake from halt runs one instruction first
// R9: low base holds bits 15-8, reset 0x80
// R10: high base holds bits 23-16, upper zero
// R11: pair register: fields at 2-0 and 10-8
// R12: field value is level, 7 highest, reset 0
// R13: twelve pairs give 24 fields in vector order
// R14: level zero requests are never accepted
// R15: highest level wins, ties to lowest vector
// R16: accept only if enabled and above current level
// R17: software unlocks with key before base changes
// R18: reserved bits ignore writes, read as zero
// R19: locked base writes are ignored
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`include "irq_params.svh"
module vectored_irq_level_control
  import irq_pkg::*;
#(
  parameter vector_t NMI_VECTOR = 5'h00
)
(
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic [`ADDR_W-1:0]      awaddr,
  input  wire logic                    awvalid,
  output wire logic                    awready,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  input  wire logic                    wvalid,
  output wire logic                    wready,
  output      logic [1:0]              bresp,
  output      logic                    bvalid,
  input  wire logic                    bready,
  input  wire logic [`ADDR_W-1:0]      araddr,
  input  wire logic                    arvalid,
  output wire logic                    arready,
  output      logic [31:0]             rdata,
  output      logic [1:0]              rresp,
  output      logic                    rvalid,
  input  wire logic                    rready,
  output wire logic                    irq,
  input  wire logic [`IRQ_SOURCES-1:0] srcReq,
  input  wire logic                    nmiReq,
  input  wire logic                    instrDone,
  input  wire logic                    haltActive,
  input  wire logic                    eiExec,
  input  wire logic                    diExec,
  input  wire logic                    retiDone,
  input  wire irq_pkg::status_s        poppedStatus,
  output wire logic                    wakeUp,
  output wire logic                    irqAccept,
  output wire logic                    pushStatusWord,
  output wire logic                    pushPc,
  output wire logic                    loadPc,
  output      logic [23:0]             vectorAddr,
  output wire irq_pkg::status_s        statusOut
);
  import irq_pkg::*;

  arb_if arbBus ();
  logic [`ADDR_W-1:0]    awAddrReg;
  logic                  awHeldReg;
  logic [15:0]           wDataReg;
  logic [1:0]            wStrbReg;
  logic                  wHeldReg;
  logic [7:0]            vblReg;
  logic [7:0]            vbhReg;
  logic [15:0]           protReg;
  logic [`EV_W-1:0]      statReg;
  logic [`EV_W-1:0]      statNext;
  logic [`EV_W-1:0]      maskReg;
  level_t                lvlReg [`IRQ_SOURCES];
  entry_state_e          stateReg;
  entry_state_e          stateNext;
  logic                  ieReg;
  level_t                ilReg;
  level_t                accLvlReg;
  logic                  accNmiReg;

  // write channel: address and data may arrive in either order
  wire wrFire = awHeldReg && wHeldReg && !bvalid;
  assign awready = !awHeldReg;
  assign wready  = !wHeldReg;
  always_ff @(posedge clk)
  begin
    if (rst)
      awHeldReg <= 1'b0;
    else if (awvalid && awready)
      awHeldReg <= 1'b1;
    else if (wrFire)
      awHeldReg <= 1'b0;
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      wHeldReg <= 1'b0;
    else if (wvalid && wready)
      wHeldReg <= 1'b1;
    else if (wrFire)
      wHeldReg <= 1'b0;
  end
  always_ff @(posedge clk)
  begin
    if (awvalid && awready)
      awAddrReg <= awaddr;
    if (wvalid && wready)
    begin
      wDataReg <= wdata[15:0];
      wStrbReg <= wstrb[1:0];
    end
  end

  // write decode
  wire       wrVbl   = awAddrReg == `OFF_VBL;
  wire       wrVbh   = awAddrReg == `OFF_VBH;
  wire       wrProt  = awAddrReg == `OFF_PROTECT_KEY;
  wire       wrStat  = awAddrReg == `OFF_STAT;
  wire       wrMask  = awAddrReg == `OFF_MASK;
  wire       wrCore  = awAddrReg == `OFF_CORE;
  wire       wrLvl   = awAddrReg >= `OFF_LVL0 && awAddrReg <= `OFF_LVL_LAST
                       && awAddrReg[1:0] == 2'b00;
  wire [3:0] wrPair  = 4'(awAddrReg[5:2] - `LVL_BASE_IDX);
  wire       wrHit   = wrVbl || wrVbh || wrProt || wrStat || wrMask
                       || wrCore || wrLvl;
  wire       protOpen = protReg == `PROTECT_KEY_KEY;
  wire       baseWr  = wrFire && (wrVbl || wrVbh);
  wire       protViol = baseWr && !protOpen;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      bvalid <= 1'b0;
      bresp  <= `RESP_OKAY;
    end
    else if (wrFire)
    begin
      bvalid <= 1'b1;
      bresp  <= wrHit ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // base registers only move while the protect key is in place
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      vblReg <= `VBL_RST;                                    // see R9
      vbhReg <= `VBH_RST;                                    // see R10
    end
    else if (baseWr && protOpen)                             // see R19
    begin
      if (wrVbl && wStrbReg[1])
        vblReg <= wDataReg[15:8];                            // see R9
      if (wrVbh && wStrbReg[0])
        vbhReg <= wDataReg[7:0];                             // see R10
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      protReg <= `PROTECT_KEY_RST;
    else if (wrFire && wrProt)
    begin
      if (wStrbReg[0])
        protReg[7:0] <= wDataReg[7:0];
      if (wStrbReg[1])
        protReg[15:8] <= wDataReg[15:8];
    end
  end

  // one 3-bit field per source; pair g/2, lane g%2
  for (genvar g = 0; g < `IRQ_SOURCES; g++)
  begin : gLevel
    localparam int LSB = (g % 2 == 1) ? `LVL_HI_LSB : `LVL_LO_LSB;
    always_ff @(posedge clk)
    begin
      if (rst)
        lvlReg[g] <= `LVL_RST;                               // see R12
      else if (wrFire && wrLvl && wrPair == 4'(g / 2) && wStrbReg[g % 2])
        lvlReg[g] <= wDataReg[LSB +: `LVL_W];                // see R11, R13
    end
    assign arbBus.level[g] = lvlReg[g];
  end
  assign arbBus.req = srcReq;

  level_arbiter uArb
  (
    .bus (arbBus.arb)
  );

  // sticky event bits, set wins over a write-one clear
  wire [`EV_W-1:0] events = {protViol, irqAccept};
  wire [`EV_W-1:0] w1c = (wrFire && wrStat && wStrbReg[0])
                         ? wDataReg[`EV_W-1:0] : '0;
  assign statNext = (statReg & ~w1c) | events;
  assign irq = |(statReg & maskReg);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      statReg <= '0;
      maskReg <= '0;
    end
    else
    begin
      statReg <= statNext;
      if (wrFire && wrMask && wStrbReg[0])
        maskReg <= wDataReg[`EV_W-1:0];
    end
  end

  // read channel
  wire [3:0]  rdPair = 4'(araddr[5:2] - `LVL_BASE_IDX);
  wire        rdLvl  = araddr >= `OFF_LVL0 && araddr <= `OFF_LVL_LAST
                       && araddr[1:0] == 2'b00;
  wire [15:0] rdLvlWord = {5'h00, lvlReg[{rdPair, 1'b1}],
                           5'h00, lvlReg[{rdPair, 1'b0}]};   // see R18
  wire [15:0] rdCore = {9'h000, stateReg, ilReg, ieReg};
  wire        rdHit  = araddr == `OFF_VBL || araddr == `OFF_VBH
                       || araddr == `OFF_PROTECT_KEY || araddr == `OFF_STAT
                       || araddr == `OFF_MASK || araddr == `OFF_CORE || rdLvl;
  wire [15:0] rdWord =
    araddr == `OFF_VBL  ? {vblReg, 8'h00} :                  // see R9
    araddr == `OFF_VBH  ? {8'h00, vbhReg} :                  // see R10
    araddr == `OFF_PROTECT_KEY ? {15'h0000, protOpen} :
    araddr == `OFF_STAT ? {14'h0000, statReg} :
    araddr == `OFF_MASK ? {14'h0000, maskReg} :
    araddr == `OFF_CORE ? rdCore :
    rdLvl               ? rdLvlWord : 16'h0000;
  assign arready = !rvalid;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= `RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rdata  <= {16'h0000, rdWord};
      rresp  <= rdHit ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (rready)
      rvalid <= 1'b0;
  end

  // core interrupt entry
  wire maskableOk = arbBus.valid && ieReg && arbBus.lvl > ilReg; // see R16
  wire eligible   = nmiReq || maskableOk;                    // see R6
  assign irqAccept = stateReg == S_IDLE && eligible;         // see R1
  assign wakeUp    = irqAccept && haltActive;                // see R8
  assign pushStatusWord = stateReg == S_PUSH_SR;             // see R2
  assign pushPc    = stateReg == S_PUSH_PC;
  assign loadPc    = stateReg == S_VECTOR;                   // see R5
  assign statusOut = '{il: ilReg, ie: ieReg};
  always_comb
  begin
    stateNext = stateReg;
    unique case (stateReg)
      S_IDLE    : if (irqAccept) stateNext = S_WAIT;
      // halt wake also lands here, so one instruction runs first
      S_WAIT    : if (instrDone) stateNext = S_PUSH_SR;      // see R1, R8
      S_PUSH_SR : stateNext = S_PUSH_PC;
      S_PUSH_PC : stateNext = S_MASK;
      S_MASK    : stateNext = S_VECTOR;
      S_VECTOR  : stateNext = S_IDLE;
      default   : stateNext = S_IDLE;
    endcase
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      stateReg <= S_IDLE;
    else
      stateReg <= stateNext;
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      accLvlReg  <= '0;
      accNmiReg  <= 1'b0;
      vectorAddr <= 24'h00_0000;
    end
    else if (irqAccept)
    begin
      accLvlReg  <= arbBus.lvl;
      accNmiReg  <= nmiReq;
      // table is 256-byte aligned so the offset is spliced in
      vectorAddr <= {vbhReg, vblReg, 1'b0,
                     nmiReq ? NMI_VECTOR : arbBus.vec, 2'b00}; // see R5
    end
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ieReg <= 1'b0;
      ilReg <= '0;
    end
    else if (stateReg == S_MASK)
    begin
      ieReg <= 1'b0;                                         // see R3
      if (!accNmiReg)
        ilReg <= accLvlReg;                                  // see R4
    end
    else if (stateReg == S_IDLE && retiDone)
    begin
      ieReg <= poppedStatus.ie;                              // see R7
      ilReg <= poppedStatus.il;
    end
    else if (stateReg == S_IDLE && eiExec)
      ieReg <= 1'b1;
    else if (stateReg == S_IDLE && diExec)
      ieReg <= 1'b0;
  end

  // checks
  sequence seqEntryTail;
    pushStatusWord ##1 pushPc ##1 stateReg == S_MASK ##1 loadPc;
  endsequence
  AST_ENTRY_ORDER: assert property (@(posedge clk) disable iff (rst) // see R2
    stateReg == S_WAIT && instrDone |=> seqEntryTail)
    else $error("entry steps out of order");
  AST_WAIT_INSTR: assert property (@(posedge clk) disable iff (rst) // see R1
    stateReg == S_WAIT && !instrDone |=> stateReg == S_WAIT)
    else $error("entry began before instruction end");
  AST_IE_CLEAR: assert property (@(posedge clk) disable iff (rst) // see R3
    stateReg == S_MASK |=> !ieReg && loadPc)
    else $error("enable not cleared on entry");
  AST_IL_LOAD: assert property (@(posedge clk) disable iff (rst) // see R4
    stateReg == S_MASK && !accNmiReg |=> ilReg == $past(accLvlReg))
    else $error("level not loaded on entry");
  AST_NMI_IL: assert property (@(posedge clk) disable iff (rst) // see R4
    stateReg == S_MASK && accNmiReg |=> $stable(ilReg))
    else $error("non-maskable entry changed level");
  AST_ACCEPT_COND: assert property (@(posedge clk) disable iff (rst) // see R16
    irqAccept && !nmiReq |-> ieReg && arbBus.lvl > ilReg
                             && arbBus.lvl != `LVL_RST)
    else $error("request accepted against enable or level");
  AST_LVL_ZERO: assert property (@(posedge clk) disable iff (rst) // see R14
    irqAccept && !nmiReq |=> accLvlReg != `LVL_RST)
    else $error("level zero request accepted");
  AST_RETI: assert property (@(posedge clk) disable iff (rst) // see R7
    stateReg == S_IDLE && retiDone |=> statusOut == $past(poppedStatus))
    else $error("status not restored on return");
  AST_PROTECT_KEY: assert property (@(posedge clk) disable iff (rst) // see R19
    protViol |=> $stable(vblReg) && $stable(vbhReg) && statReg[`EV_PROTVIOL])
    else $error("locked base register changed");
  AST_WAKE: assert property (@(posedge clk) disable iff (rst) // see R8
    wakeUp |=> stateReg == S_WAIT ##1 !loadPc)
    else $error("wake skipped the extra instruction");
endmodule : vectored_irq_level_control
